// [logic/lp_seq_pkg.sv]
/*
 Package for the low-power mode sequencer: states, modes, wake cause
 encodings and timing constants.
 Assumes a 20 MHz system clock.
*/
package lp_seq_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_MHZ = 20;
   // Wake times kept in nanoseconds (3.5 us and 60 us)
   localparam int STOP_WAKE_NS = 3500;
   localparam int STBY_WAKE_NS = 60000;
   localparam int CLK_NS = 1000 / CLK_MHZ;
   // Longest times round down
   localparam int STOP_WAKE_CYC = STOP_WAKE_NS / CLK_NS;
   localparam int STBY_WAKE_CYC = STBY_WAKE_NS / CLK_NS;
   localparam int CNT_W = 12;
   // Settle count sits two cycles below the limit, so resume lands on the limit
   localparam logic [CNT_W-1:0] STOP_SETTLE =
      CNT_W'(STOP_WAKE_CYC - 2);
   localparam logic [CNT_W-1:0] STBY_SETTLE =
      CNT_W'(STBY_WAKE_CYC - 2);
   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int EVT_W = 16;
   localparam int PIN_W = 3;
   localparam int CAUSE_W = 4;

   // ----------------------------------------
   // Modes and states
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_STOP = 2'b00,
      MODE_STBY_RTC = 2'b01,
      MODE_STBY_NORTC = 2'b10
   } lp_mode_t;

   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_STOP = 3'b001,
      ST_STBY = 3'b010,
      ST_WAKE = 3'b011,
      ST_RESET = 3'b100
   } lp_state_t;

   // Wake cause bit positions in the status register
   localparam int C_EXT_RST = 0;
   localparam int C_WDG_RST = 1;
   localparam int C_PIN = 2;
   localparam int C_RTC = 3;
   localparam logic [CAUSE_W-1:0] CAUSE_NONE = 4'h0;
endpackage : lp_seq_pkg

// [logic/wake_if.sv]
/*
 Interface between the sequencer and its wake collector.
 Assumes both ends share clk_sys.
*/
`timescale 1ns/1ns
interface wake_if;
   import lp_seq_pkg::*;
   logic stop_wake;
   logic stby_wake;
   logic [CAUSE_W-1:0] cause;
   logic in_stop;
   logic in_stby;
   logic rtc_on;
   modport collector (output stop_wake, stby_wake, cause,
      input in_stop, in_stby, rtc_on);
   modport sequencer (input stop_wake, stby_wake, cause,
      output in_stop, in_stby, rtc_on);
endinterface : wake_if

// [logic/wake_collect.sv]
/*
 Wake collector: qualifies event lines, peripheral wakes, wake pin
 edges, resets and clock events into stop and standby wake requests.
 Assumes all inputs synchronous to clk_sys.
*/
`timescale 1ns/1ns
module wake_collect
   import lp_seq_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Sources
   input wire logic [lp_seq_pkg::EVT_W-1:0] pin_evt,
   input wire logic supply_level_detector,
   input wire logic [1:0] cmp_evt,
   input wire logic vref_on,
   input wire logic [4:0] periph_wake,
   input wire logic [lp_seq_pkg::PIN_W-1:0] wake_pin,
   input wire logic external_reset_pin_n,
   input wire logic wdg_reset,
   input wire logic [4:0] rtc_evt,
   // Sequencer side
   wake_if.collector w
);
   logic [PIN_W-1:0] pin_q_ff;
   logic pin_rise;
   logic ext_line;

   // Rising-edge memory for wake pins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_q_ff <= '0;
      end else begin
         pin_q_ff <= wake_pin;
      end
   end

   assign pin_rise = |(wake_pin & ~pin_q_ff);
   // Comparators only count with reference on
   assign ext_line = (|pin_evt) | supply_level_detector |
      ((|cmp_evt) & vref_on);

   // Stop wakes on any event line or peripheral wake
   assign w.stop_wake = w.in_stop & (ext_line | (|periph_wake));
   // Clock events and watchdog only matter with the clock kept
   assign w.stby_wake = w.in_stby & (~external_reset_pin_n | pin_rise |
      (w.rtc_on & (wdg_reset | (|rtc_evt))));
   assign w.cause = {w.rtc_on & (|rtc_evt), pin_rise,
      w.rtc_on & wdg_reset, ~external_reset_pin_n};

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Comparators alone never wake stop while the reference is off
   property p_cmp_gate;
      @(posedge clk_sys) disable iff (rst)
      w.in_stop && !vref_on && pin_evt == '0 && !supply_level_detector &&
         periph_wake == '0 |-> !w.stop_wake;
   endproperty
   a_cmp_gate: assert property (p_cmp_gate)
      else $error("comparator woke without reference");

   // Without the kept clock only a reset or a pin may end standby
   property p_norc;
      @(posedge clk_sys) disable iff (rst)
      w.in_stby && !w.rtc_on && wake_pin == '0 && external_reset_pin_n |->
         !w.stby_wake;
   endproperty
   a_norc: assert property (p_norc)
      else $error("standby without clock woke on other source");
endmodule : wake_collect

// [logic/lp_sequencer.sv]
/*
 Low-power mode sequencer top: enters stop or standby on a deep-sleep
 request and brings the device back within the fixed wake times.
 Assumes synchronous inputs and a 20 MHz clk_sys.
*/
`timescale 1ns/1ns
module lp_sequencer
   import lp_seq_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Processor side
   input wire logic deep_sleep_req,
   input wire logic [1:0] lp_mode_sel,
   input wire logic rtc_enable,
   input wire logic wdg_enable,
   input wire logic cause_clear,
   // Wake sources
   input wire logic [lp_seq_pkg::EVT_W-1:0] pin_evt,
   input wire logic supply_level_detector,
   input wire logic [1:0] cmp_evt,
   input wire logic vref_on,
   input wire logic [4:0] periph_wake,
   input wire logic periph_hsi_req,
   input wire logic [lp_seq_pkg::PIN_W-1:0] wake_pin,
   input wire logic external_reset_pin_n,
   input wire logic wdg_reset,
   input wire logic [4:0] rtc_evt,
   // Power and clock controls
   output logic clocks_run,
   output logic pll_on,
   output logic high_speed_internal_osc_on,
   output logic high_speed_crystal_osc_on,
   output logic multispeed_internal_osc_on,
   output logic low_speed_internal_osc_on,
   output logic low_speed_crystal_osc_on,
   output logic regulator_on,
   output logic regulator_low_power,
   output logic core_domain_on,
   output logic retain_state,
   output logic core_reset,
   output logic cpu_resume,
   output logic [1:0] lp_state_code,
   output logic [lp_seq_pkg::CAUSE_W-1:0] reset_clock_status_reg
);
   import lp_seq_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   lp_state_t state_ff, nxt_state;
   logic [CNT_W-1:0] cnt_ff;
   logic rtc_keep_ff;
   logic [CAUSE_W-1:0] cause_ff;
   logic [CNT_W-1:0] stby_exit_ff;
   lp_mode_t mode;
   wake_if w ();

   assign mode = lp_mode_t'(lp_mode_sel);
   assign w.in_stop = (state_ff == ST_STOP);
   assign w.in_stby = (state_ff == ST_STBY);
   assign w.rtc_on = rtc_keep_ff;

   wake_collect u_wake (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin_evt(pin_evt),
      .supply_level_detector(supply_level_detector),
      .cmp_evt(cmp_evt),
      .vref_on(vref_on),
      .periph_wake(periph_wake),
      .wake_pin(wake_pin),
      .external_reset_pin_n(external_reset_pin_n),
      .wdg_reset(wdg_reset),
      .rtc_evt(rtc_evt),
      .w(w)
   );

   // ----------------------------------------
   // Sequencing
   // ----------------------------------------
   // Next state from request, wake and settle counter
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_RUN: begin
            if (deep_sleep_req) begin
               nxt_state = (mode == MODE_STOP) ? ST_STOP : ST_STBY;
            end
         end
         ST_STOP: begin
            if (w.stop_wake) begin
               nxt_state = ST_WAKE;
            end
         end
         ST_STBY: begin
            if (w.stby_wake) begin
               nxt_state = ST_RESET;
            end
         end
         ST_WAKE, ST_RESET: begin
            if (cnt_ff == CNT_ZERO) begin
               nxt_state = ST_RUN;
            end
         end
         default: nxt_state = ST_RUN;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_ff <= ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Settle counter loaded on a wake; bounds exit latency
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_ff <= CNT_ZERO;
      end else if (state_ff == ST_STOP && w.stop_wake) begin
         cnt_ff <= STOP_SETTLE;
      end else if (state_ff == ST_STBY && w.stby_wake) begin
         cnt_ff <= STBY_SETTLE;
      end else if (cnt_ff != CNT_ZERO) begin
         cnt_ff <= cnt_ff - 12'h001;
      end
   end

   // Whether the slow clock survives standby, latched at entry
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rtc_keep_ff <= 1'b0;
      end else if (state_ff == ST_RUN && deep_sleep_req) begin
         rtc_keep_ff <= (mode != MODE_STBY_NORTC) & rtc_enable;
      end
   end

   // Wake cause lives in standby circuitry; new cause beats clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cause_ff <= CAUSE_NONE;
      end else if (state_ff == ST_STBY && w.stby_wake) begin
         cause_ff <= w.cause;
      end else if (cause_clear) begin
         cause_ff <= CAUSE_NONE;
      end
   end

   // ----------------------------------------
   // Outputs, all registered
   // ----------------------------------------
   // Derived from next state so controls change with the state
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         clocks_run <= 1'b1;
         pll_on <= 1'b1;
         high_speed_internal_osc_on <= 1'b1;
         high_speed_crystal_osc_on <= 1'b1;
         multispeed_internal_osc_on <= 1'b1;
         low_speed_internal_osc_on <= 1'b1;
         low_speed_crystal_osc_on <= 1'b1;
         regulator_on <= 1'b1;
         regulator_low_power <= 1'b0;
         core_domain_on <= 1'b1;
         retain_state <= 1'b1;
         core_reset <= 1'b0;
         cpu_resume <= 1'b0;
         lp_state_code <= 2'h0;
         reset_clock_status_reg <= CAUSE_NONE;
      end else begin
         // Stop: clocks, PLL and fast oscs off, fast internal osc only on peripheral demand; regulator and core domain stay on
         clocks_run <= !(nxt_state inside {ST_STOP, ST_STBY});
         pll_on <= !(nxt_state inside {ST_STOP, ST_STBY});
         high_speed_internal_osc_on <= (nxt_state == ST_STOP) ?
            periph_hsi_req : (nxt_state != ST_STBY);
         high_speed_crystal_osc_on <=
            !(nxt_state inside {ST_STOP, ST_STBY});
         multispeed_internal_osc_on <=
            !(nxt_state inside {ST_STOP, ST_STBY});
         // Slow oscs follow the watchdog and clock enables
         low_speed_internal_osc_on <= (nxt_state inside {ST_STOP,
            ST_STBY}) ? (wdg_enable | (nxt_state == ST_STBY &&
            rtc_keep_ff)) : 1'b1;
         low_speed_crystal_osc_on <= (nxt_state inside {ST_STOP,
            ST_STBY}) ? (nxt_state == ST_STBY ? rtc_keep_ff :
            rtc_enable) : 1'b1;
         regulator_on <= (nxt_state != ST_STBY);
         regulator_low_power <= (nxt_state == ST_STOP);
         core_domain_on <= (nxt_state != ST_STBY);
         retain_state <= (nxt_state != ST_STBY);
         core_reset <= (nxt_state inside {ST_STBY, ST_RESET});
         cpu_resume <= (state_ff == ST_WAKE) && (nxt_state == ST_RUN);
         lp_state_code <= (nxt_state == ST_STOP) ? 2'h1 :
            (nxt_state == ST_STBY) ? 2'h2 : 2'h0;
         reset_clock_status_reg <= cause_ff;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_stop_off;
      @(posedge clk_sys) disable iff (rst)
      state_ff == ST_STOP && $past(state_ff) == ST_STOP |->
         !clocks_run && !pll_on && !multispeed_internal_osc_on;
   endproperty
   a_stop_off: assert property (p_stop_off)
      else $error("clocks running in stop");

   property p_hsi;
      @(posedge clk_sys) disable iff (rst)
      state_ff == ST_STOP && nxt_state == ST_STOP |=>
         high_speed_internal_osc_on == $past(periph_hsi_req);
   endproperty
   a_hsi: assert property (p_hsi)
      else $error("fast osc not following peripheral demand");

   property p_reg_lp;
      @(posedge clk_sys) disable iff (rst)
      nxt_state == ST_STOP |=> regulator_low_power && regulator_on;
   endproperty
   a_reg_lp: assert property (p_reg_lp)
      else $error("regulator not low power in stop");

   property p_stop_wake;
      @(posedge clk_sys) disable iff (rst)
      state_ff == ST_STOP && w.stop_wake |-> ##[1:70] cpu_resume;
   endproperty
   a_stop_wake: assert property (p_stop_wake)
      else $error("stop wake too slow");

   property p_periph;
      @(posedge clk_sys) disable iff (rst)
      state_ff == ST_STOP && periph_wake != '0 |=> state_ff == ST_WAKE;
   endproperty
   a_periph: assert property (p_periph)
      else $error("peripheral wake ignored");

   property p_stby_off;
      @(posedge clk_sys) disable iff (rst)
      nxt_state == ST_STBY |=> !regulator_on && !core_domain_on &&
         !retain_state && core_reset;
   endproperty
   a_stby_off: assert property (p_stby_off)
      else $error("core domain alive in standby");

   // Cycles since a standby wake while the core is still held in reset;
   // a counter keeps the long 60 us bound cheap to check
   always_ff @(posedge clk_sys) begin
      if (rst || !core_reset) begin
         stby_exit_ff <= CNT_ZERO;
      end else if (stby_exit_ff != CNT_ZERO || w.stby_wake) begin
         stby_exit_ff <= stby_exit_ff + 12'h001;
      end
   end

   property p_stby_exit;
      @(posedge clk_sys) disable iff (rst)
      core_reset && stby_exit_ff != CNT_ZERO |->
         stby_exit_ff < CNT_W'(STBY_WAKE_CYC);
   endproperty
   a_stby_exit: assert property (p_stby_exit)
      else $error("standby exit too slow");

   property p_cause;
      @(posedge clk_sys) disable iff (rst)
      state_ff == ST_STBY && w.stby_wake |=> cause_ff == $past(w.cause);
   endproperty
   a_cause: assert property (p_cause)
      else $error("wake cause not recorded");

   c_stop: cover property (@(posedge clk_sys) state_ff == ST_STOP ##1
      state_ff == ST_WAKE);
   c_stby: cover property (@(posedge clk_sys) state_ff == ST_STBY ##1
      state_ff == ST_RESET);
   c_resume: cover property (@(posedge clk_sys) cpu_resume);
endmodule : lp_sequencer

// [tb/wake_src_model.sv]
/*
 Wake source model: pins, reset pin, watchdog, clock events and
 peripheral wakes, pulsed on command from the bench.
 Assumes the bench raises fire for one cycle with kind and idx.
*/
`timescale 1ns/1ns
module wake_src_model
   import lp_seq_pkg::*;
(
   // Clock
   input wire logic clk_sys,
   // Command
   input wire logic fire,
   input wire logic [2:0] kind,
   input wire logic [3:0] idx,
   // Wake sources
   output logic [lp_seq_pkg::EVT_W-1:0] pin_evt,
   output logic supply_level_detector,
   output logic [1:0] cmp_evt,
   output logic [4:0] periph_wake,
   output logic [lp_seq_pkg::PIN_W-1:0] wake_pin,
   output logic external_reset_pin_n,
   output logic wdg_reset,
   output logic [4:0] rtc_evt
);
   logic [2:0] hold_ff;

   // Idle levels from time zero
   initial begin
      pin_evt = '0;
      supply_level_detector = 1'b0;
      cmp_evt = 2'h0;
      periph_wake = 5'h00;
      wake_pin = '0;
      external_reset_pin_n = 1'b1;
      wdg_reset = 1'b0;
      rtc_evt = 5'h00;
      hold_ff = 3'h0;
   end

   // Events last one cycle; a wake pin stays high a while, so a
   // sampler that wants an edge sees the rise only once
   always @(posedge clk_sys) begin
      pin_evt <= '0;
      supply_level_detector <= 1'b0;
      cmp_evt <= 2'h0;
      periph_wake <= 5'h00;
      external_reset_pin_n <= 1'b1;
      wdg_reset <= 1'b0;
      rtc_evt <= 5'h00;
      if (hold_ff != 3'h0) begin
         hold_ff <= hold_ff - 3'h1;
      end else begin
         wake_pin <= '0;
      end
      if (fire) begin
         case (kind)
            3'h0: pin_evt[idx] <= 1'b1;
            3'h1: supply_level_detector <= 1'b1;
            3'h2: cmp_evt[idx[0]] <= 1'b1;
            3'h3: periph_wake[idx] <= 1'b1;
            3'h4: begin
               wake_pin[idx[1:0]] <= 1'b1;
               hold_ff <= 3'h4;
            end
            3'h5: external_reset_pin_n <= 1'b0;
            3'h6: wdg_reset <= 1'b1;
            default: rtc_evt[idx] <= 1'b1;
         endcase
      end
   end
endmodule : wake_src_model

// [tb/test_low_power_mode_sequencer.sv]
/*
 Bench for lp_sequencer: every wake source in its mode, refused
 sources, then random cases. Assumes wake_src_model beside it.
*/
`timescale 1ns/1ns
module test_low_power_mode_sequencer;
   import lp_seq_pkg::*;
   logic clk_sys, rst, deep_sleep_req, rtc_enable, wdg_enable;
   logic cause_clear, vref_on, periph_hsi_req, fire;
   logic supply_level_detector, external_reset_pin_n, wdg_reset;
   logic [1:0] lp_mode_sel, cmp_evt, lp_state_code;
   logic [2:0] kind;
   logic [3:0] idx;
   logic [EVT_W-1:0] pin_evt;
   logic [4:0] periph_wake, rtc_evt;
   logic [PIN_W-1:0] wake_pin;
   logic clocks_run, pll_on, high_speed_internal_osc_on;
   logic high_speed_crystal_osc_on, multispeed_internal_osc_on;
   logic low_speed_internal_osc_on, low_speed_crystal_osc_on;
   logic regulator_on, regulator_low_power, core_domain_on;
   logic retain_state, core_reset, cpu_resume;
   logic [CAUSE_W-1:0] status;
   int err_total, num_checks;
   // Either slow oscillator counts: which one runs is left open
   wire [9:0] ctl = {clocks_run, pll_on, high_speed_internal_osc_on,
      high_speed_crystal_osc_on, multispeed_internal_osc_on,
      low_speed_internal_osc_on | low_speed_crystal_osc_on,
      regulator_on, core_domain_on, retain_state, core_reset};

   wake_src_model src (.clk_sys, .fire, .kind, .idx, .pin_evt,
      .supply_level_detector, .cmp_evt, .periph_wake, .wake_pin,
      .external_reset_pin_n, .wdg_reset, .rtc_evt);
   lp_sequencer dut (.clk_sys, .rst, .deep_sleep_req, .lp_mode_sel,
      .rtc_enable, .wdg_enable, .cause_clear, .pin_evt,
      .supply_level_detector, .cmp_evt, .vref_on, .periph_wake,
      .periph_hsi_req, .wake_pin, .external_reset_pin_n, .wdg_reset,
      .rtc_evt, .clocks_run, .pll_on, .high_speed_internal_osc_on,
      .high_speed_crystal_osc_on, .multispeed_internal_osc_on,
      .low_speed_internal_osc_on, .low_speed_crystal_osc_on,
      .regulator_on, .regulator_low_power, .core_domain_on,
      .retain_state, .core_reset, .cpu_resume, .lp_state_code,
      .reset_clock_status_reg(status));

   // ----------------------------------------
   // Expectations and checks
   // ----------------------------------------
   // Mode 3 stands for running
   function automatic logic [9:0] exp_ctl(input logic [1:0] m,
      input logic ls, input logic high_speed_internal_osc);
      case (m)
         2'h0: exp_ctl = {2'b00, high_speed_internal_osc, 2'b00, ls, 4'b1110};
         2'h3: exp_ctl = 10'h3fe;
         default: exp_ctl = {5'h00, ls, 4'h1};
      endcase
   endfunction : exp_ctl

   function automatic logic [9:0] exp_cause(input logic [2:0] k);
      case (k)
         3'h4: exp_cause = 10'h004;
         3'h5: exp_cause = 10'h001;
         3'h6: exp_cause = 10'h002;
         default: exp_cause = 10'h008;
      endcase
   endfunction : exp_cause

   // Highest line index of each source kind
   function automatic int top_idx(input logic [2:0] k);
      case (k)
         3'h0: top_idx = 15;
         3'h2: top_idx = 1;
         3'h3, 3'h7: top_idx = 4;
         3'h4: top_idx = 2;
         default: top_idx = 0;
      endcase
   endfunction : top_idx

   task automatic chk_vec(input logic [9:0] got, input logic [9:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_vec

   task automatic chk_lat(input int n, input int lim);
      num_checks++;
      if (n > lim) begin
         err_total++;
         $display("Error at %0t: wake took %h limit %h", $time, n, lim);
      end
   endtask : chk_lat

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic fire_src(input logic [2:0] k);
      @(posedge clk_sys);
      fire <= 1'b1;
      kind <= k;
      idx <= 4'($urandom_range(0, top_idx(k)));
      @(posedge clk_sys);
      fire <= 1'b0;
   endtask : fire_src

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   // ----------------------------------------
   // One sleep and wake
   // ----------------------------------------
   task automatic run_case(input logic [1:0] m, input logic [2:0] k,
      input logic r, input logic w, input logic h);
      int n;
      int lim;
      lim = (m == 2'h0) ? STOP_WAKE_CYC : STBY_WAKE_CYC;
      @(posedge clk_sys);
      lp_mode_sel <= m;
      rtc_enable <= r;
      wdg_enable <= w;
      periph_hsi_req <= h;
      deep_sleep_req <= 1'b1;
      @(posedge clk_sys);
      deep_sleep_req <= 1'b0;
      tick(2);
      chk_vec(10'(lp_state_code), (m == 2'h0) ? 10'h1 : 10'h2);
      chk_vec(ctl, exp_ctl(m, r | w, h));
      if (m == 2'h0) begin
         chk_vec(10'(regulator_low_power), 10'h1);
         // Comparator without the reference must not wake
         @(posedge clk_sys);
         vref_on <= 1'b0;
         fire_src(3'h2);
         tick(8);
         chk_vec(10'(lp_state_code), 10'h1);
         @(posedge clk_sys);
         vref_on <= 1'b1;
      end else if (m == 2'h2) begin
         fire_src(3'h7);
         fire_src(3'h6);
         tick(8);
         chk_vec(10'(lp_state_code), 10'h2);
      end
      fire_src(k);
      for (n = 1; n <= 1300; n++) begin
         @(posedge clk_sys);
         #1;
         if (m == 2'h0 ? cpu_resume === 1'b1 : core_reset === 1'b0) break;
      end
      chk_lat(n, lim);
      if (n > 1300) test_done();
      if (m != 2'h0) begin
         chk_vec(10'(status), exp_cause(k));
         @(posedge clk_sys);
         cause_clear <= 1'b1;
         @(posedge clk_sys);
         cause_clear <= 1'b0;
      end
      tick(2);
      chk_vec(10'(status), 10'h0);
      chk_vec(ctl, exp_ctl(2'h3, 1'b1, 1'b0));
      chk_vec(10'(lp_state_code), 10'h0);
      $display("Test mode %0d source %0d done", m, k);
   endtask : run_case

   // Random enables within what each mode allows
   task automatic pick(input logic [1:0] m, input logic [2:0] k);
      logic r;
      logic w;
      r = (m == 2'h1) | ((m == 2'h0) & 1'($urandom_range(0, 1)));
      w = (m != 2'h2) & 1'($urandom_range(0, 1));
      run_case(m, k, r, w, 1'($urandom_range(0, 1)));
   endtask : pick

   // ----------------------------------------
   // Clock and main sequence
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   initial begin
      logic [1:0] m;
      rst = 1'b1;
      deep_sleep_req = 1'b0;
      lp_mode_sel = 2'h0;
      rtc_enable = 1'b0;
      wdg_enable = 1'b0;
      cause_clear = 1'b0;
      vref_on = 1'b1;
      periph_hsi_req = 1'b0;
      fire = 1'b0;
      kind = 3'h0;
      idx = 4'h0;
      err_total = 0;
      num_checks = 0;
      void'($urandom(49024));
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      tick(1);
      chk_vec(ctl, exp_ctl(2'h3, 1'b1, 1'b0));
      chk_vec(10'(status), 10'h0);
      // Every source kind in its own mode, then refusals in mode 2
      for (int k = 0; k < 8; k++) begin
         pick((k < 4) ? 2'h0 : 2'h1, 3'(k));
      end
      pick(2'h2, 3'h4);
      pick(2'h2, 3'h5);
      for (int j = 0; j < 12; j++) begin
         m = 2'($urandom_range(0, 2));
         if (m == 2'h0) begin
            pick(m, 3'($urandom_range(0, 3)));
         end else begin
            pick(m, 3'($urandom_range(4, (m == 2'h1) ? 7 : 5)));
         end
      end
      test_done();
   end
endmodule : test_low_power_mode_sequencer
